/* rtl/scdsc_pkg.sv */
package scdsc_pkg;

  // ************************************************************
  // Register map
  // ************************************************************
  // Printed offsets other than 8'h54 are not multiples of four, so they are indices.
  localparam logic [7:0] TRIM_IDX = 8'h66;
  localparam logic [7:0] DIV_IDX = 8'h61;
  localparam logic [7:0] SLEEP_IDX = 8'h53;
  localparam logic [7:0] STATUS_IDX = 8'h54;
  localparam logic [7:0] FUSE_IDX = 8'h55;
  localparam int ADDR_W = 12;

  localparam int UNLOCK_BIT = 7;
  localparam int SEL_MSB = 3;
  localparam logic [7:0] UNLOCK_PATTERN = 8'h80;
  localparam logic [3:0] SEL_RESET_PLAIN = 4'h0;
  localparam logic [3:0] SEL_RESET_DIV8 = 4'h3;
  localparam logic [3:0] SEL_MAX = 4'h8;
  localparam logic [2:0] UNLOCK_CYCLES = 3'h4;
  localparam logic [2:0] WAKE_HALT_CYCLES = 3'h4;
  localparam int SLEEP_ARM_BIT = 0;
  localparam int MODE_LSB = 1;
  localparam logic [7:0] DEFAULT_TRIM = 8'h80;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ************************************************************
  // Sleep modes
  // ************************************************************
  localparam logic [2:0] MODE_IDLE = 3'h0;
  localparam logic [2:0] MODE_ADC_NR = 3'h1;
  localparam logic [2:0] MODE_PDOWN = 3'h2;
  localparam logic [2:0] MODE_PSAVE = 3'h3;
  localparam logic [2:0] MODE_STANDBY = 3'h6;
  localparam logic [2:0] MODE_EXT_STANDBY = 3'h7;

  typedef enum logic [3:0] {
    SCDSC_RUN = 4'b0001,
    SCDSC_SLEEP = 4'b0010,
    SCDSC_START = 4'b0100,
    SCDSC_HALT = 4'b1000
  } scdsc_state_e;

  typedef struct packed {
    logic core_clock_domain;
    logic flash_clock;
    logic peripheral_io_clock;
    logic converter_clock;
    logic async_clock;
    logic main_osc;
    logic timer_osc;
  } scdsc_gates_s;

  typedef struct packed {
    logic ext_irq_level;
    logic ext_irq_edge;
    logic pin_change_irq;
    logic two_wire_port_match;
    logic async_capable_timer;
    logic mem_ready;
    logic converter_done;
    logic watchdog_timer_unit;
    logic other_io;
  } scdsc_wake_s;

endpackage

/* rtl/scdsc_top.sv */
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/1ps
module scdsc_top
  import scdsc_pkg::*;
#(
  parameter logic [7:0] FACTORY_TRIM = DEFAULT_TRIM, // Arbitrary calibration value.
  parameter int START_CYCLES = 6
) (
  input wire logic aclk, // Clock.
  input wire logic aresetn, // Synchronous reset, low.
  input wire logic [ADDR_W-1:0] s_axi_awaddr, // Write address.
  input wire logic s_axi_awvalid, // Write address valid.
  output logic s_axi_awready, // Write address ready.
  input wire logic [31:0] s_axi_wdata, // Write data.
  input wire logic [3:0] s_axi_wstrb, // Write strobes.
  input wire logic s_axi_wvalid, // Write data valid.
  output logic s_axi_wready, // Write data ready.
  output logic [1:0] s_axi_bresp, // Write response.
  output logic s_axi_bvalid, // Write response valid.
  input wire logic s_axi_bready, // Write response ready.
  input wire logic [ADDR_W-1:0] s_axi_araddr, // Read address.
  input wire logic s_axi_arvalid, // Read address valid.
  output logic s_axi_arready, // Read address ready.
  output logic [31:0] s_axi_rdata, // Read data.
  output logic [1:0] s_axi_rresp, // Read response.
  output logic s_axi_rvalid, // Read data valid.
  input wire logic s_axi_rready, // Read ready.
  input wire logic divide_by_eight_fuse, // Fuse pin, high when programmed.
  input wire logic async_timer_on_async, // Async timer uses its own clock.
  input wire logic sleep_instr, // Sleep instruction executes, pulse.
  input wire logic bod_disable_req, // Software brown-out disable asked.
  input wire scdsc_wake_s wake_in, // Wake events from pins and units.
  output logic [7:0] trim_value, // Trim code to the oscillator.
  output logic sys_clk_en, // Divided system clock enable.
  output scdsc_gates_s gates, // Running clock domains.
  output logic brownout_off, // Brown-out monitor off.
  output logic core_halt, // Core stalled.
  output logic wake_irq, // Wake via interrupt, pulse.
  output logic wake_reset // Wake was by reset, restart at vector.
);

  if (START_CYCLES < 1 || START_CYCLES > 255) begin : g_bad_start
    $error("START_CYCLES out of range");
  end

  function automatic logic [7:0] pow2_mask(input logic [3:0] sel);
    pow2_mask = 8'((9'h001 << sel) - 9'h001);
  endfunction

  function automatic logic known_mode(input logic [2:0] m);
    known_mode = (m == MODE_IDLE) || (m == MODE_ADC_NR) || (m == MODE_PDOWN) ||
      (m == MODE_PSAVE) || (m == MODE_STANDBY) || (m == MODE_EXT_STANDBY);
  endfunction

  // ************************************************************
  // Input synchronisers
  // ************************************************************
  // Pins go through two stages; only the second is read. Its top bit marks that pin values have arrived.
  logic [11:0] sync1_reg;
  logic [11:0] sync2_reg;
  logic fuse_s;
  logic async_s;
  scdsc_wake_s wake_s;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_reg <= 12'h000;
      sync2_reg <= 12'h000;
    end else begin
      sync1_reg <= {1'b1, divide_by_eight_fuse, async_timer_on_async, wake_in};
      sync2_reg <= sync1_reg;
    end
  end
  assign fuse_s = sync2_reg[10];
  assign async_s = sync2_reg[9];
  assign wake_s = sync2_reg[8:0];

  // ************************************************************
  // AXI4-Lite slave
  // ************************************************************
  logic aw_hold_reg;
  logic w_hold_reg;
  logic [ADDR_W-1:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic wr_fire;
  logic [7:0] wr_idx;
  logic wr_lane0;
  logic [7:0] wbyte;
  assign wr_fire = aw_hold_reg && w_hold_reg && !s_axi_bvalid;
  assign wr_idx = awaddr_reg[9:2];
  assign wr_lane0 = wstrb_reg[0] && (awaddr_reg[ADDR_W-1:10] == 2'h0);
  assign wbyte = wdata_reg[7:0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_reg <= 1'b0;
      awaddr_reg <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_hold_reg <= 1'b1;
      awaddr_reg <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_hold_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_hold_reg <= 1'b0;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_hold_reg <= 1'b1;
      wdata_reg <= s_axi_wdata;
      wstrb_reg <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_hold_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_hold_reg && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready <= !w_hold_reg && !(s_axi_wvalid && s_axi_wready);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (wr_idx == TRIM_IDX || wr_idx == DIV_IDX || wr_idx == SLEEP_IDX ||
        wr_idx == STATUS_IDX || wr_idx == FUSE_IDX) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ************************************************************
  // Oscillator trim
  // ************************************************************
  // The code passes straight to the oscillator; bit 7 is the range bit.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trim_value <= FACTORY_TRIM;
    end else if (wr_fire && wr_lane0 && wr_idx == TRIM_IDX) begin
      trim_value <= wbyte;
    end
  end

  // ************************************************************
  // Divider control
  // ************************************************************
  logic unlock_reg;
  logic [2:0] unlock_cnt_reg;
  logic [3:0] sel_reg;
  logic sel_loaded_reg;
  logic div_wr;
  assign div_wr = wr_fire && wr_lane0 && wr_idx == DIV_IDX;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      unlock_reg <= 1'b0;
      unlock_cnt_reg <= 3'h0;
    end else if (div_wr && wbyte == UNLOCK_PATTERN) begin
      if (!unlock_reg) begin
        unlock_reg <= 1'b1;
        unlock_cnt_reg <= UNLOCK_CYCLES;
      end else begin
        unlock_cnt_reg <= unlock_cnt_reg - 3'h1;
        unlock_reg <= unlock_cnt_reg != 3'h1;
      end
    end else if (unlock_reg) begin
      unlock_cnt_reg <= unlock_cnt_reg - 3'h1;
      unlock_reg <= !(div_wr || unlock_cnt_reg == 3'h1);
    end
  end

  // The fuse is loaded once, as soon as its level has crossed both sync stages after release.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sel_reg <= SEL_RESET_PLAIN;
      sel_loaded_reg <= 1'b0;
    end else if (!sel_loaded_reg && sync2_reg[11]) begin
      sel_loaded_reg <= 1'b1;
      sel_reg <= fuse_s ? SEL_RESET_DIV8 : SEL_RESET_PLAIN;
    end else if (div_wr && unlock_reg && !wbyte[UNLOCK_BIT]) begin
      sel_reg <= wbyte[SEL_MSB:0];
    end
  end

  // Synchronous counter at the undivided rate; a new rate starts at the next wrap so no short pulse appears.
  logic [7:0] div_cnt_reg;
  logic [3:0] active_sel_reg;
  logic [7:0] div_mask;

  assign div_mask = pow2_mask(active_sel_reg);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_cnt_reg <= 8'h00;
      active_sel_reg <= SEL_RESET_PLAIN;
      sys_clk_en <= 1'b0;
    end else if ((div_cnt_reg & div_mask) == div_mask) begin
      div_cnt_reg <= 8'h00;
      sys_clk_en <= 1'b1;
      // Reserved codes keep the old rate rather than invent one.
      active_sel_reg <= (sel_reg <= SEL_MAX) ? sel_reg : active_sel_reg;
    end else begin
      div_cnt_reg <= div_cnt_reg + 8'h01;
      sys_clk_en <= 1'b0;
    end
  end

  // ************************************************************
  // Sleep controller
  // ************************************************************
  logic arm_reg;
  logic [2:0] mode_reg;
  scdsc_state_e state_reg;
  logic [7:0] wait_reg;
  logic wake_int;
  logic deep;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arm_reg <= 1'b0;
      mode_reg <= MODE_IDLE;
    end else if (wr_fire && wr_lane0 && wr_idx == SLEEP_IDX) begin
      arm_reg <= wbyte[SLEEP_ARM_BIT];
      mode_reg <= wbyte[MODE_LSB+2:MODE_LSB];
    end
  end

  assign deep = mode_reg != MODE_IDLE;

  always_comb begin
    wake_int = wake_s.pin_change_irq || wake_s.two_wire_port_match || wake_s.watchdog_timer_unit ||
      wake_s.ext_irq_level || (!deep && wake_s.ext_irq_edge);
    unique case (mode_reg)
      MODE_IDLE: begin
        wake_int = wake_int || wake_s.async_capable_timer || wake_s.mem_ready ||
          wake_s.converter_done || wake_s.other_io;
      end
      MODE_ADC_NR: begin
        wake_int = wake_int || (async_s && wake_s.async_capable_timer) || wake_s.mem_ready ||
          wake_s.converter_done;
      end
      MODE_PSAVE, MODE_EXT_STANDBY: begin
        wake_int = wake_int || wake_s.async_capable_timer;
      end
      default: wake_int = wake_int;
    endcase
  end

  // Register file and SRAM sit outside; only clocks stop, so contents stay.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= SCDSC_RUN;
      wait_reg <= 8'h00;
      wake_irq <= 1'b0;
    end else begin
      wake_irq <= 1'b0;
      unique case (state_reg)
        SCDSC_RUN: begin
          if (sleep_instr && arm_reg && known_mode(mode_reg)) begin
            state_reg <= SCDSC_SLEEP;
          end
        end
        SCDSC_SLEEP: begin
          if (wake_int) begin
            state_reg <= SCDSC_START;
            wait_reg <= 8'(START_CYCLES);
          end
        end
        SCDSC_START: begin
          wait_reg <= wait_reg - 8'h01;
          if (wait_reg == 8'h01) begin
            state_reg <= SCDSC_HALT;
            wait_reg <= {5'h00, WAKE_HALT_CYCLES};
          end
        end
        SCDSC_HALT: begin
          wait_reg <= wait_reg - 8'h01;
          if (wait_reg == 8'h01) begin
            state_reg <= SCDSC_RUN;
            wake_irq <= 1'b1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wake_reset <= 1'b1;
    end else if (state_reg == SCDSC_SLEEP) begin
      wake_reset <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gates <= '1;
      brownout_off <= 1'b0;
      core_halt <= 1'b0;
    end else begin
      gates <= '1;
      brownout_off <= 1'b0;
      core_halt <= state_reg != SCDSC_RUN;
      if (state_reg == SCDSC_SLEEP) begin
        brownout_off <= bod_disable_req && mode_reg != MODE_IDLE && mode_reg != MODE_ADC_NR;
        gates.core_clock_domain <= 1'b0;
        gates.flash_clock <= 1'b0;
        gates.peripheral_io_clock <= mode_reg == MODE_IDLE;
        gates.converter_clock <= mode_reg == MODE_IDLE || mode_reg == MODE_ADC_NR;
        gates.async_clock <= mode_reg == MODE_IDLE || mode_reg == MODE_ADC_NR ||
          mode_reg == MODE_PSAVE || (mode_reg == MODE_EXT_STANDBY && async_s);
        gates.main_osc <= mode_reg != MODE_PDOWN && mode_reg != MODE_PSAVE;
        gates.timer_osc <= async_s && (mode_reg == MODE_IDLE || mode_reg == MODE_ADC_NR ||
          mode_reg == MODE_PSAVE || mode_reg == MODE_EXT_STANDBY);
      end
    end
  end

  // ************************************************************
  // Read channel
  // ************************************************************
  logic [7:0] rd_idx;
  logic rd_bad;
  logic [7:0] rd_byte;

  assign rd_idx = s_axi_araddr[9:2];
  always_comb begin
    rd_bad = s_axi_araddr[ADDR_W-1:10] != 2'h0;
    rd_byte = 8'h00;
    if (rd_idx == TRIM_IDX) begin
      rd_byte = trim_value;
    end else if (rd_idx == DIV_IDX) begin
      rd_byte = {unlock_reg, 3'h0, sel_reg};
    end else if (rd_idx == SLEEP_IDX) begin
      rd_byte = {4'h0, mode_reg, arm_reg};
    end else if (rd_idx == STATUS_IDX) begin
      rd_byte = {4'h0, state_reg};
    end else if (rd_idx == FUSE_IDX) begin
      rd_byte = {6'h00, async_s, fuse_s};
    end else begin
      rd_bad = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h00_0000, rd_bad ? 8'h00 : rd_byte};
        s_axi_rresp <= rd_bad ? RESP_SLVERR : RESP_OKAY;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule

/* tb/scdsc_top_monitor.sv */
`timescale 1ns/1ps
module scdsc_monitor
  import scdsc_pkg::*;
#(
  parameter logic [7:0] FACTORY_TRIM = DEFAULT_TRIM
) (
  input wire logic aclk, // Clock.
  input wire logic aresetn, // Reset, low.
  input wire logic sleep_instr, // Sleep pulse.
  input wire logic [7:0] trim_value, // Trim code.
  input wire scdsc_gates_s gates, // Running domains.
  input wire logic brownout_off, // Monitor off.
  input wire logic core_halt, // Core stalled.
  input wire logic wake_irq, // Wake pulse.
  input wire logic wake_reset // Reset path flag.
);
  // ************************************************************
  // Sleep timing, gating, brown-out and reset checks
  // ************************************************************
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_enter;
    $rose(core_halt);
  endsequence

  sequence s_halted4;
    core_halt [*4];
  endsequence

  // Start-up and the extra halt cycles keep the core stopped longer than four cycles.
  a_min_halt: assert property (s_enter |-> s_halted4)
    else $error("core resumed too soon after sleep entry");
  a_sleep_cause: assert property (s_enter |-> $past(sleep_instr) || $past(sleep_instr, 2) || $past(sleep_instr, 3))
    else $error("core halted without a sleep instruction");
  a_wake_halt: assert property (wake_irq |-> $past(core_halt) && $past(core_halt, 4))
    else $error("wake pulse without four halted cycles");
  a_wake_pulse: assert property (wake_irq |=> !wake_irq)
    else $error("wake pulse longer than one cycle");
  a_core_gated: assert property (!gates.core_clock_domain |-> core_halt)
    else $error("core clock stopped while core runs");
  a_flash_core: assert property (gates.flash_clock == gates.core_clock_domain)
    else $error("flash clock differs from core clock");
  a_io_adc: assert property (gates.peripheral_io_clock |-> gates.converter_clock)
    else $error("io clock runs without converter clock");
  a_bod_deep: assert property (brownout_off && $past(brownout_off) |-> core_halt && !gates.converter_clock)
    else $error("brown-out monitor off outside deep sleep");
  a_trim_reset: assert property ($rose(aresetn) |-> trim_value == FACTORY_TRIM)
    else $error("trim not loaded with factory value");
  a_wake_reset: assert property ($rose(aresetn) |-> wake_reset)
    else $error("reset path flag low after reset");
endmodule

bind scdsc_top scdsc_monitor #(.FACTORY_TRIM(FACTORY_TRIM)) u_mon (
  .aclk, .aresetn, .sleep_instr, .trim_value, .gates, .brownout_off, .core_halt, .wake_irq, .wake_reset
);

/* tb/test_sysclk_divider_and_sleep_ctrl.sv */
`timescale 1ns/1ps
module test_sysclk_divider_and_sleep_ctrl;
  import scdsc_pkg::*;
  localparam logic [7:0] TRIM_P = 8'h5A; // Arbitrary calibration value.
  localparam int START_P = 6;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 4'h1;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic divide_by_eight_fuse = 1'b1, async_timer_on_async = 1'b1, sleep_instr = 1'b0, bod_disable_req = 1'b1;
  logic [7:0] trim_value;
  logic sys_clk_en, brownout_off, core_halt, wake_irq, wake_reset;
  scdsc_wake_s wake_in = '0;
  scdsc_gates_s gates;
  int err_count = 0, checks_done = 0, n;

  always #20 aclk = ~aclk;

  scdsc_top #(.FACTORY_TRIM(TRIM_P), .START_CYCLES(START_P)) dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .divide_by_eight_fuse, .async_timer_on_async, .sleep_instr, .bod_disable_req, .wake_in,
    .trim_value, .sys_clk_en, .gates, .brownout_off, .core_halt, .wake_irq, .wake_reset
  );

  // ************************************************************
  // Shared helpers
  // ************************************************************
  task automatic wrap_up();
    if (err_count == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Response ready is raised at the start and never lowered at the end, so
  // back-to-back calls never drive one signal twice in one time step.
  task automatic bus(bit wr, logic [7:0] idx, logic [7:0] d, logic [1:0] er = RESP_OKAY, logic [3:0] st = 4'h1);
    bit done;
    done = 1'b0;
    s_axi_bready <= wr;
    s_axi_rready <= !wr;
    if (wr) begin
      s_axi_awaddr <= {2'h0, idx, 2'h0};
      s_axi_wdata <= {24'h0, d};
      s_axi_wstrb <= st;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
    end else begin
      s_axi_araddr <= {2'h0, idx, 2'h0};
      s_axi_arvalid <= 1'b1;
    end
    for (int k = 0; k < 100 && !done; k++) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_bready && s_axi_bvalid === 1'b1) begin
        done = 1'b1;
        chk("bresp", er, s_axi_bresp);
      end
      if (s_axi_rready && s_axi_rvalid === 1'b1) begin
        done = 1'b1;
        rd = s_axi_rdata;
        chk("rresp", er, s_axi_rresp);
      end
    end
    if (!done) begin
      chk("bus timeout", 1, 0);
      wrap_up();
    end
  endtask

  task automatic rchk(logic [7:0] idx, logic [31:0] exp);
    bus(1'b0, idx, 8'h0);
    chk($sformatf("reg %h", idx), exp, rd);
  endtask

  task automatic await(ref logic s);
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (s !== 1'b1 && n < 600);
    if (s !== 1'b1) begin
      chk("wait timeout", 1, 0);
      wrap_up();
    end
  endtask

  task automatic enter(logic [2:0] m, logic a);
    bus(1'b1, SLEEP_IDX, {4'h0, m, a});
    sleep_instr <= 1'b1;
    @(posedge aclk);
    sleep_instr <= 1'b0;
    repeat (3) @(posedge aclk);
  endtask

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_reset_values(logic f);
    divide_by_eight_fuse <= f;
    aresetn <= 1'b0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (4) @(posedge aclk);
    rchk(TRIM_IDX, {24'h0, TRIM_P});
    rchk(DIV_IDX, f ? 32'h3 : 32'h0);
    rchk(STATUS_IDX, 32'h1);
    chk("wake_reset", 1, wake_reset);
  endtask

  task automatic t_trim();
    logic [7:0] tv [3] = '{8'h7F, 8'h80, 8'h00};
    foreach (tv[i]) begin
      bus(1'b1, TRIM_IDX, tv[i]);
      chk("trim_value", tv[i], trim_value);
    end
  endtask

  task automatic t_unlock();
    bus(1'b1, DIV_IDX, 8'h81);
    bus(1'b1, DIV_IDX, 8'h05);
    rchk(DIV_IDX, 32'h3);
    bus(1'b1, DIV_IDX, UNLOCK_PATTERN);
    bus(1'b1, DIV_IDX, UNLOCK_PATTERN);
    bus(1'b1, DIV_IDX, 8'h05);
    rchk(DIV_IDX, 32'h3);
    bus(1'b1, DIV_IDX, UNLOCK_PATTERN);
    bus(1'b1, DIV_IDX, 8'h07);
    rchk(DIV_IDX, 32'h7);
    bus(1'b1, DIV_IDX, UNLOCK_PATTERN);
    repeat (6) @(posedge aclk);
    bus(1'b1, DIV_IDX, 8'h01);
    rchk(DIV_IDX, 32'h7);
  endtask

  task automatic t_rates();
    for (int c = 0; c < 10; c++) begin
      bus(1'b1, DIV_IDX, UNLOCK_PATTERN);
      bus(1'b1, DIV_IDX, 8'(c));
      rchk(DIV_IDX, 32'(c));
      repeat (3) await(sys_clk_en);
      chk("period", c > 8 ? 256 : 1 << c, n);
    end
    bus(1'b1, DIV_IDX, UNLOCK_PATTERN);
    bus(1'b1, DIV_IDX, 8'h00);
  endtask

  task automatic t_bus_errs();
    bus(1'b0, 8'h00, 8'h00, RESP_SLVERR);
    chk("rdata", 0, rd);
    bus(1'b1, STATUS_IDX, 8'hFF);
    rchk(STATUS_IDX, 32'h1);
    bus(1'b1, TRIM_IDX, 8'h33, RESP_OKAY, 4'hE);
    rchk(TRIM_IDX, 32'h0);
  endtask

  task automatic t_modes();
    logic [2:0] md [6] = '{MODE_IDLE, MODE_ADC_NR, MODE_PDOWN, MODE_PSAVE, MODE_STANDBY, MODE_EXT_STANDBY};
    logic [6:0] gx [6] = '{7'h1F, 7'h0F, 7'h00, 7'h05, 7'h02, 7'h07};
    logic [8:0] nw [6] = '{9'h000, 9'h081, 9'h09D, 9'h08D, 9'h09D, 9'h08D};
    logic [8:0] wk [6] = '{9'h001, 9'h004, 9'h040, 9'h010, 9'h020, 9'h100};
    for (int i = 0; i < 6; i++) begin
      enter(md[i], 1'b1);
      chk("gates", gx[i], gates);
      chk("brownout_off", i > 1, brownout_off);
      rchk(STATUS_IDX, 32'h2);
      wake_in <= nw[i];
      repeat (12) @(posedge aclk);
      chk("core_halt", 1, core_halt);
      wake_in <= wk[i];
      await(wake_irq);
      wake_in <= '0;
      chk("halt_time", 1, n >= START_P + 4);
      repeat (2) @(posedge aclk);
      chk("gates_run", 7'h7F, gates);
    end
    rchk(TRIM_IDX, 32'h0);
  endtask

  task automatic t_no_sleep();
    enter(MODE_IDLE, 1'b0);
    chk("no_arm", 0, core_halt);
    enter(3'h4, 1'b1);
    chk("bad_mode", 0, core_halt);
    async_timer_on_async <= 1'b0;
    enter(MODE_ADC_NR, 1'b1);
    wake_in <= 9'h010;
    repeat (12) @(posedge aclk);
    chk("sync_timer", 1, core_halt);
    wake_in <= 9'h002;
    await(wake_irq);
    wake_in <= '0;
    enter(MODE_PSAVE, 1'b1);
    chk("psave_sync", 7'h04, gates);
    wake_in <= 9'h002;
    await(wake_irq);
    wake_in <= '0;
    async_timer_on_async <= 1'b1;
  endtask

  task automatic t_reset_sleep();
    enter(MODE_PDOWN, 1'b1);
    chk("asleep", 1, core_halt);
    chk("wake_reset", 0, wake_reset);
    t_reset_values(1'b0);
    chk("core_halt", 0, core_halt);
  endtask

  initial begin
    t_reset_values(1'b1);
    t_trim();
    t_unlock();
    t_rates();
    t_bus_errs();
    t_modes();
    t_no_sleep();
    t_reset_sleep();
    wrap_up();
  end
endmodule
